// >>> include/gear_sense_pkg.sv
/*
 * Constants and types of the adaptive threshold switch logic.
 * Assumes one 10 MHz clock and unsigned processed samples.
 */
package gear_sense_pkg;
	localparam int SIG_W         = 10;
	localparam int CODE_W        = 4;
	localparam int PCT_W         = 7;
	localparam int PCT_BASE      = 40;
	localparam int PCT_STEP      = 2;
	localparam int PCT_MAX       = 60;
	localparam int PCT_FULL      = 100;
	localparam int HYS_PCT       = 16;
	localparam int HYS_HALF      = HYS_PCT / 2;
	localparam int CAL_EDGES     = 3;
	localparam int STOP_EDGES    = 3;
	localparam int CLK_PERIOD_NS = 100;
	localparam int WDOG_TIME_US  = 20000;
	localparam int STOP_TIME_US  = 5000;
	// Longest times, so rounded down
	localparam int WDOG_CYCLES   = WDOG_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int STOP_CYCLES   = STOP_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam logic [SIG_W-1:0] LOCK_SPAN_DEF = 10'h040;
	localparam logic [SIG_W-1:0] PEAK_RST      = 10'h000;
	localparam logic [PCT_W-1:0] PCT_RST       = 7'h28;
	localparam logic             OUT_POS       = 1'b0;
	localparam logic [31:0]      CNT_RST       = 32'h0000_0000;

	typedef enum {
		st_calibrate,
		st_run,
		st_lockout,
		st_stop
	} mode_t;
endpackage

// >>> hdl/peak_hold.sv
/*
 * One peak-holding tracker, following either the positive or the
 * negative peak of the processed sensor signal.
 * Assumes samples arrive on the same clock with a valid strobe.
 */
`timescale 1ns/1ns
module peak_hold #(
	parameter bit TRACK_MAX = 1'b1
) (
	input  wire logic                              clock,
	input  wire logic                              rst_n,
	input  wire logic                              clock_en,
	input  wire logic                              clear,
	input  wire logic                              reload,
	input  wire logic                              sample_valid,
	input  wire logic [gear_sense_pkg::SIG_W-1:0]  sample,
	output logic      [gear_sense_pkg::SIG_W-1:0]  peak
);
	import gear_sense_pkg::*;

	logic empty;
	wire  beyond = TRACK_MAX ? (sample > peak) : (sample < peak);
	// Reload restarts the hunt so the held peak can follow drift inward
	wire  take   = sample_valid && (empty || reload || beyond);

	// [R01] peak follows signal
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			peak  <= PEAK_RST;
			empty <= 1'b1;
		end else if (clock_en) begin
			if (clear) begin
				peak  <= PEAK_RST;
				empty <= 1'b1;
			end else if (take) begin
				peak  <= sample;
				empty <= 1'b0;
			end
		end
	end

	peak_follow_a: assert property ( // [R01]
		@(posedge clock) disable iff (!rst_n)
		clock_en && sample_valid && !clear && beyond
			|=> peak == $past(sample))
		else $error("held peak missed a new extreme");
endmodule

// >>> hdl/threshold_switch.sv
/*
 * Decision logic of a differential gear-tooth sensor: peak tracking,
 * programmable percentage thresholds, lockout, stop, watchdog.
 * Assumes samples from the analog front end on the same clock, and
 * asynchronous pins for undervoltage and rotation direction.
 */
// Contract
// [R01] Hold two peak values, positive and negative, tracking while running.
// [R02] Switching thresholds are a fraction of the span between held peaks.
// [R03] Fraction is stored, programmable 40 to 60 percent, used every switch.
// [R04] Span below minimum counts as vibration and locks out switching.
// [R05] Lockout holds output level; resume only when amplitude is normal.
// [R06] Watchdog self-resets processing when output stops toggling.
// [R07] After watchdog reset, calibrate again before running switching.
// [R08] Undervoltage holds logic in reset with output at power-on level.
// [R09] Output inactive during calibration, first active at first switch point.
// [R10] After calibration enter running with peak tracking still active.
// [R11] Stop mode needs several target edges before running resumes.
// [R12] Output high on tooth for reference direction, inverted on reverse.
// [R13] Watchdog timeout is a parameter in clock cycles; lockout level LOCK_SPAN is a parameter, a span in signal units.
`timescale 1ns/1ns
module threshold_switch #(
	parameter int                              WDOG_LIMIT =
		gear_sense_pkg::WDOG_CYCLES,
	parameter int                              STOP_LIMIT =
		gear_sense_pkg::STOP_CYCLES,
	parameter logic [gear_sense_pkg::SIG_W-1:0] LOCK_SPAN  =
		gear_sense_pkg::LOCK_SPAN_DEF
) (
	input  wire logic                              clock,
	input  wire logic                              rst_n,
	input  wire logic                              clock_en,
	input  wire logic                              sample_valid,
	input  wire logic [gear_sense_pkg::SIG_W-1:0]  processed_sensor_signal,
	input  wire logic [gear_sense_pkg::CODE_W-1:0] threshold_code,
	input  wire logic                              reverse_pin,
	input  wire logic                              undervoltage_pin,
	output logic                                   switch_out,
	output gear_sense_pkg::mode_t                  mode,
	output logic                                   lockout_flag
);
	import gear_sense_pkg::*;

	function automatic logic [SIG_W-1:0] frac_of(
		input logic [SIG_W-1:0] span_in,
		input logic [PCT_W-1:0] pct_in
	);
		logic [SIG_W+PCT_W-1:0] prod;
		prod    = span_in * pct_in;
		frac_of = SIG_W'(prod / PCT_FULL);
	endfunction

	logic             uv_meta, uv_sync, dir_meta, dir_sync;
	logic [PCT_W-1:0] pct_reg;
	logic             above;
	logic [31:0]      edge_cnt, idle_cnt, wdog_cnt;
	mode_t            next_mode;
	logic [SIG_W-1:0] hi_peak, lo_peak;

	// Pins are asynchronous: two stages before use
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			uv_meta  <= 1'b1;
			uv_sync  <= 1'b1;
			dir_meta <= 1'b0;
			dir_sync <= 1'b0;
		end else if (clock_en) begin
			uv_meta  <= undervoltage_pin;
			uv_sync  <= uv_meta;
			dir_meta <= reverse_pin;
			dir_sync <= dir_meta;
		end
	end

	wire in_cal    = (mode == st_calibrate);
	wire wdog_fire = !in_cal && (wdog_cnt >= 32'(WDOG_LIMIT - 1));
	wire soft_rst  = uv_sync || wdog_fire;

	// Code above range clamps to the top setting
	wire [PCT_W-1:0] code_pct = PCT_W'(PCT_BASE + PCT_STEP * threshold_code);
	wire [PCT_W-1:0] pct_new  =
		(code_pct > PCT_W'(PCT_MAX)) ? PCT_W'(PCT_MAX) : code_pct;

	// [R02] span between peaks
	wire [SIG_W-1:0] span     = (hi_peak > lo_peak) ? hi_peak - lo_peak : '0;
	// [R03] fraction with hysteresis
	wire [SIG_W-1:0] rise_thr = lo_peak + frac_of(span,
		pct_reg + PCT_W'(HYS_HALF));
	wire [SIG_W-1:0] fall_thr = lo_peak + frac_of(span,
		pct_reg - PCT_W'(HYS_HALF));

	wire rise_hit = sample_valid && !above &&
		(processed_sensor_signal >= rise_thr);
	wire fall_hit = sample_valid && above &&
		(processed_sensor_signal < fall_thr);
	wire feature  = rise_hit || fall_hit;
	wire low_amp  = (span < LOCK_SPAN);
	wire tooth    = rise_hit ? 1'b1 : (fall_hit ? 1'b0 : above);
	wire idle_out = (idle_cnt >= 32'(STOP_LIMIT - 1));
	wire cal_done = feature && (edge_cnt >= 32'(CAL_EDGES - 1));
	wire stop_done = feature && (edge_cnt >= 32'(STOP_EDGES - 1));
	wire out_drive = (mode == st_run) && feature && !low_amp;
	// [R12] polarity by direction
	wire out_level = tooth ^ dir_sync;

	// [R10] tracking stays on
	// Restart on the crossing toward own peak; the other peak stays held
	peak_hold #(.TRACK_MAX(1'b1)) hi_track (
		.clock        (clock),
		.rst_n        (rst_n),
		.clock_en     (clock_en),
		.clear        (soft_rst),
		.reload       (rise_hit),
		.sample_valid (sample_valid),
		.sample       (processed_sensor_signal),
		.peak         (hi_peak)
	);

	peak_hold #(.TRACK_MAX(1'b0)) lo_track (
		.clock        (clock),
		.rst_n        (rst_n),
		.clock_en     (clock_en),
		.clear        (soft_rst),
		.reload       (fall_hit),
		.sample_valid (sample_valid),
		.sample       (processed_sensor_signal),
		.peak         (lo_peak)
	);

	always_comb begin
		next_mode = mode;
		case (mode)
			// [R10] calibration into running
			st_calibrate: begin
				if (cal_done)
					next_mode = st_run;
			end
			// [R04] vibration lockout
			st_run: begin
				if (low_amp)
					next_mode = st_lockout;
				else if (idle_out)
					next_mode = st_stop;
			end
			// [R05] resume at normal amplitude
			st_lockout: begin
				if (!low_amp)
					next_mode = st_run;
			end
			// [R11] edges to leave stop
			st_stop: begin
				if (stop_done)
					next_mode = st_run;
			end
			default: next_mode = st_calibrate;
		endcase
		// [R07] watchdog back to calibration
		if (soft_rst)
			next_mode = st_calibrate;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			mode <= st_calibrate;
		else if (clock_en)
			mode <= next_mode;
	end

	// [R03] setting stored during calibration
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			pct_reg <= PCT_RST;
		else if (clock_en && in_cal)
			pct_reg <= pct_new;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			above <= 1'b0;
		else if (clock_en)
			above <= soft_rst ? 1'b0 : tooth;
	end

	// Counts features in every mode, read in calibration and stop; cleared on mode change
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			edge_cnt <= CNT_RST;
		else if (clock_en)
			edge_cnt <= (soft_rst || next_mode != mode) ? CNT_RST :
				(feature ? edge_cnt + 32'd1 : edge_cnt);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			idle_cnt <= CNT_RST;
		else if (clock_en)
			idle_cnt <= (soft_rst || feature) ? CNT_RST : idle_cnt + 32'd1;
	end

	// [R06] cycles without output toggle
	// [R13] limit is a parameter
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			wdog_cnt <= CNT_RST;
		else if (clock_en)
			wdog_cnt <= (soft_rst || in_cal ||
				(out_drive && out_level != switch_out)) ?
				CNT_RST : wdog_cnt + 32'd1;
	end

	// [R08] power-on level in reset
	// [R09] quiet until first switch point
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			switch_out <= OUT_POS;
		else if (clock_en) begin
			if (soft_rst)
				switch_out <= OUT_POS;
			else if (out_drive)
				switch_out <= out_level;
		end
	end

	assign lockout_flag = (mode == st_lockout);

	uv_reset_a: assert property ( // [R08]
		@(posedge clock) disable iff (!rst_n)
		clock_en && uv_sync |=> switch_out == OUT_POS && mode == st_calibrate)
		else $error("undervoltage did not force reset state");

	cal_quiet_a: assert property ( // [R09]
		@(posedge clock) disable iff (!rst_n)
		mode == st_calibrate |-> switch_out == OUT_POS)
		else $error("output active during calibration");

	lock_enter_a: assert property ( // [R04]
		@(posedge clock) disable iff (!rst_n)
		clock_en && mode == st_run && low_amp && !soft_rst
			|=> mode == st_lockout)
		else $error("small signal did not lock out");

	lock_hold_a: assert property ( // [R05]
		@(posedge clock) disable iff (!rst_n)
		mode == st_lockout ##1 mode == st_lockout |-> $stable(switch_out))
		else $error("output moved during lockout");

	wdog_cal_a: assert property ( // [R07]
		@(posedge clock) disable iff (!rst_n)
		clock_en && wdog_fire |=> mode == st_calibrate && edge_cnt == 0)
		else $error("watchdog did not restart calibration");

	wdog_bound_a: assert property ( // [R06]
		@(posedge clock) disable iff (!rst_n)
		wdog_cnt < 32'(WDOG_LIMIT))
		else $error("watchdog overran its limit");

	cal_run_a: assert property ( // [R10]
		@(posedge clock) disable iff (!rst_n)
		mode == st_calibrate ##1 mode == st_run
			|-> $past(edge_cnt) == 32'(CAL_EDGES - 1))
		else $error("calibration ended on wrong edge count");

	stop_exit_a: assert property ( // [R11]
		@(posedge clock) disable iff (!rst_n)
		mode == st_stop ##1 mode == st_run
			|-> $past(edge_cnt) == 32'(STOP_EDGES - 1))
		else $error("stop left without enough edges");

	polarity_a: assert property ( // [R12]
		@(posedge clock) disable iff (!rst_n)
		clock_en && out_drive && rise_hit && !soft_rst
			|=> switch_out == !$past(dir_sync))
		else $error("output polarity wrong on rising feature");

	pct_range_a: assert property ( // [R03]
		@(posedge clock) disable iff (!rst_n)
		pct_reg >= PCT_W'(PCT_BASE) && pct_reg <= PCT_W'(PCT_MAX))
		else $error("stored threshold fraction out of range");

	thr_inside_a: assert property ( // [R02]
		@(posedge clock) disable iff (!rst_n)
		hi_peak > lo_peak |-> fall_thr >= lo_peak && rise_thr <= hi_peak
			&& fall_thr <= rise_thr)
		else $error("thresholds outside peak span");

	run_c: cover property (@(posedge clock) mode == st_run && out_drive);
	lock_c: cover property (@(posedge clock) mode == st_lockout);
	stop_c: cover property (@(posedge clock) mode == st_stop ##1 mode == st_run);
	wdog_c: cover property (@(posedge clock) wdog_fire);
endmodule

// >>> tb/ecu_model.sv
/* Engine controller model: reads the sensor output line each clock.
 * Assumes the bench clock and the bench reset. */
`timescale 1ns/1ns
module ecu_model (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic switch_out,
	output int        edges,
	output logic      level
);
	// Edge count lets the bench see a silent line
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			edges <= 0;
			level <= 1'b0;
		end else begin
			level <= switch_out;
			if (switch_out !== level)
				edges <= edges + 1;
		end
	end
endmodule

// >>> tb/tb_top.sv
/* Self-checking bench of the threshold switch logic.
 * Assumes shortened watchdog and stop counts. */
`timescale 1ns/1ns
module tb_top;
	import gear_sense_pkg::*;
	localparam int WDOG  = 400;
	localparam int STOPC = 100;
	logic                clock = 1'b0;
	logic                rst_n = 1'b0;
	logic                valid = 1'b0;
	logic [SIG_W-1:0]    sig   = 10'h000;
	logic [CODE_W-1:0]   code  = 4'h5;
	logic                rev   = 1'b0;
	logic                uv    = 1'b0;
	logic                en    = 1'b1;
	logic                sw;
	logic                lock;
	mode_t               mode;
	int                  edges;
	logic                level;
	int                  n_fail  = 0;
	int                  checked = 0;

	always #50 clock = ~clock;

	threshold_switch #(.WDOG_LIMIT(WDOG), .STOP_LIMIT(STOPC),
		.LOCK_SPAN(LOCK_SPAN_DEF)) threshold_switch_i (
		.clock(clock), .rst_n(rst_n), .clock_en(en),
		.sample_valid(valid), .processed_sensor_signal(sig),
		.threshold_code(code), .reverse_pin(rev),
		.undervoltage_pin(uv), .switch_out(sw), .mode(mode),
		.lockout_flag(lock));
	ecu_model ecu_model_i (.clock(clock), .rst_n(rst_n),
		.switch_out(sw), .edges(edges), .level(level));

	task automatic wrap_up();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk_bit(input logic got, input logic exp,
		input string what);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t %s got %b", $time, what, got);
		end
	endtask

	task automatic chk_mode(input mode_t exp);
		checked++;
		if (mode !== exp) begin
			n_fail++;
			$display("[ERR] %0t mode %s", $time, mode.name());
		end
	endtask

	task automatic chk_cnt(input int got, input int exp, input string what);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t %s got %0d", $time, what, got);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// Burst of n samples at one level, then one quiet edge
	task automatic send(input logic [SIG_W-1:0] v, input int n);
		repeat (n) begin
			@(posedge clock);
			valid <= 1'b1;
			sig <= v;
		end
		@(posedge clock);
		valid <= 1'b0;
		idle(1);
	endtask

	// Soft reset through the supply pin, then calibrate to run
	task automatic run_up(input logic [CODE_W-1:0] c);
		uv <= 1'b1;
		code <= c;
		idle(4);
		uv <= 1'b0;
		idle(4);
		for (int i = 0; i < 8 && mode !== st_run; i++) begin
			send(i[0] ? 10'h000 : 10'h3FF, 8);
			chk_bit(sw, OUT_POS, "calib out");
		end
		chk_mode(st_run);
	endtask

	task automatic t_polarity(input logic r);
		rev <= r;
		idle(4);
		// Start from a valley so the tooth burst is a crossing
		send(10'h000, 8);
		send(10'h3FF, 8);
		chk_bit(sw, ~r, "tooth level");
		send(10'h000, 8);
		chk_bit(sw, r, "valley level");
		rev <= 1'b0;
		idle(4);
	endtask

	// Mid-level sample switches only at or above the programmed rising threshold
	task automatic t_pct();
		int pct;
		int rise;
		for (int c = 0; c < 16; c += 5) begin
			pct = PCT_BASE + PCT_STEP * c;
			if (pct > PCT_MAX)
				pct = PCT_MAX;
			rise = 1023 * (pct + HYS_HALF) / PCT_FULL;
			run_up(c[CODE_W-1:0]);
			send(10'h000, 8);
			send(10'h200, 8);
			chk_bit(sw, 512 >= rise, "fraction");
		end
	endtask

	// Crossings that shrink the span until it reads as vibration
	task automatic t_lockout();
		send(10'h3FF, 4);
		send(10'h0F0, 4);
		send(10'h2C0, 4);
		send(10'h1A0, 4);
		send(10'h250, 4);
		send(10'h1E8, 4);
		send(10'h224, 4);
		chk_bit(lock, 1'b1, "lockout");
		chk_bit(sw, 1'b1, "held level");
		send(10'h000, 8);
		chk_bit(sw, 1'b1, "no switch on exit");
		send(10'h3FF, 8);
		send(10'h000, 8);
		send(10'h3FF, 8);
		chk_bit(lock, 1'b0, "resume");
		send(10'h000, 8);
		chk_bit(sw, 1'b0, "resumed switch");
	endtask

	// Low enable freezes everything, even a clear crossing
	task automatic t_freeze();
		en <= 1'b0;
		send(10'h3FF, 8);
		chk_bit(sw, 1'b0, "frozen out");
		chk_mode(st_run);
		en <= 1'b1;
		idle(2);
	endtask

	task automatic t_stop_wdog();
		int seen;
		idle(STOPC + 4);
		chk_mode(st_stop);
		send(10'h3FF, 8);
		send(10'h000, 8);
		chk_mode(st_stop);
		send(10'h3FF, 8);
		chk_mode(st_run);
		send(10'h000, 8);
		send(10'h3FF, 8);
		chk_bit(sw, 1'b1, "before self-reset");
		seen = edges;
		idle(WDOG + 10);
		chk_mode(st_calibrate);
		chk_bit(level, OUT_POS, "after self-reset");
		chk_cnt(edges, seen + 1, "edges at self-reset");
	endtask

	task automatic t_uv();
		run_up(4'h5);
		send(10'h000, 8);
		send(10'h3FF, 8);
		uv <= 1'b1;
		idle(3);
		chk_bit(sw, OUT_POS, "uv out");
		send(10'h000, 8);
		send(10'h3FF, 8);
		chk_mode(st_calibrate);
		chk_bit(sw, OUT_POS, "uv hold");
		uv <= 1'b0;
		idle(4);
	endtask

	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		idle(4);
		run_up(4'h5);
		t_polarity(1'b0);
		t_polarity(1'b1);
		t_lockout();
		t_freeze();
		t_stop_wdog();
		t_pct();
		t_uv();
		wrap_up();
	end

	// Whole run needs well under ten thousand cycles
	initial begin
		#(30000 * 100);
		n_fail++;
		wrap_up();
	end
endmodule
